// ---- src/asm_cmd_pkg.sv ----
// Constants, types and register map of the assembled move command decoder
// Operation
// [R1] Command 16#2000 starts the stored assembled profile
// [R2] Word1 bit9 picks dwell, bit4 reverses blend
// [R3] Same programming for blend and dwell profiles
// [R4] Word9 is dwell milliseconds, ignored when blending
// [R5] Unused command words are ignored entirely
// [R6] Command 16#4000 loads encoder from words 2,3
// [R7] Command 16#0800 opens profile programming, no parameters
// [R8] Opening block sets status bits 8 and 9
// [R9] Host waits for bits 8 and 9
// [R10] Segment block is 16#1800, one stored segment
// [R11] Host keeps segment parameters within limits
// [R12] Host writes zero into segment word 8
// [R13] Bit12 seen: capture segment, clear status bit9
// [R14] Host clears bit12 after bit9 clears
// [R15] Bit12 low again: set status bit9
// [R16] At most sixteen segments are stored
// [R17] Status bit9 ready, bit8 programming mode
// [R18] Status bit12 invalid command, cleared by reset
// [R19] Segments run in arrival order from first
package asm_cmd_pkg;

  // Command word 0 codes
  localparam logic [15:0] CMD_NONE       = 16'h0000;
  localparam logic [15:0] CMD_RESET_ERR  = 16'h0400;
  localparam logic [15:0] CMD_PROG_OPEN  = 16'h0800;
  localparam logic [15:0] CMD_SEGMENT    = 16'h1800;
  localparam logic [15:0] CMD_RUN_ASSY   = 16'h2000;
  localparam logic [15:0] CMD_PRESET_ENC = 16'h4000;

  // Bit positions in command and status words
  localparam int CMD0_SEG_BIT     = 12;
  localparam int CMD1_DWELL_BIT   = 9;
  localparam int CMD1_REVERSE_BIT = 4;
  localparam int ST0_MOVE_CMP     = 7;
  localparam int ST0_IN_ASSY      = 8;
  localparam int ST0_WAIT_SEG     = 9;
  localparam int ST0_CMD_ERR      = 12;
  localparam int ST0_MODULE_OK    = 14;

  // Command image layout
  localparam int CMD_WORDS   = 10;
  localparam int W_CMD0      = 0;
  localparam int W_CMD1      = 1;
  localparam int W_POS_HI    = 2;
  localparam int W_POS_LO    = 3;
  localparam int W_SPD_HI    = 4;
  localparam int W_SPD_LO    = 5;
  localparam int W_ACCEL     = 6;
  localparam int W_DECEL     = 7;
  localparam int W_JERK      = 9;
  localparam int W_DWELL     = 9;

  // Segment storage
  localparam int SEG_DEPTH   = 16;
  localparam int SEG_IDX_W   = 4;
  localparam int SEG_CNT_W   = 5;

  // Encoder preset limits
  localparam logic signed [31:0] ENC_MIN = -32'sd8388608;
  localparam logic signed [31:0] ENC_MAX = 32'sd8388607;

  // Register byte addresses (command words at index times four)
  localparam logic [7:0] ADR_CMD_BASE = 8'h00;
  localparam logic [7:0] ADR_CMD_LAST = 8'h24;
  localparam logic [7:0] ADR_STATUS0  = 8'h40;
  localparam logic [7:0] ADR_ENC_POS  = 8'h44;
  localparam logic [7:0] ADR_SEG_CNT  = 8'h48;
  localparam logic [7:0] ADR_RUN_CFG  = 8'h4C;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h50;
  localparam logic [7:0] ADR_IRQ_MASK = 8'h54;

  // Interrupt event bits
  localparam int IRQ_W        = 4;
  localparam int EV_CMD_ERR   = 0;
  localparam int EV_SEG_TAKEN = 1;
  localparam int EV_RUN_START = 2;
  localparam int EV_RUN_DONE  = 3;

  // Reset values
  localparam logic [15:0] CMD_WORD_RST = 16'h0000;
  localparam logic [31:0] ENC_RST      = 32'h0000_0000;

  // One stored profile segment
  typedef struct packed {
    logic [31:0] rel_target;  // Relative target, steps
    logic [31:0] speed;       // Programmed speed
    logic [15:0] accel;       // Acceleration
    logic [15:0] decel;       // Deceleration
    logic [15:0] jerk;        // Acceleration jerk
  } segment_t;

  // Execution style latched at run
  typedef struct packed {
    logic        dwell;       // 1 dwell, 0 blend
    logic        reverse;     // Reverse blend direction
    logic [15:0] dwell_ms;    // Pause between segments
  } run_cfg_t;

  // Decoder states
  typedef enum logic [1:0] {
    ST_IDLE      = 2'b00,
    ST_PROG_WAIT = 2'b01,
    ST_PROG_HOLD = 2'b10,
    ST_RUN       = 2'b11
  } dec_state_t;

endpackage

// ---- src/asm_seg_store.sv ----
// Segment memory written in arrival order, read by index
`timescale 1ns/10ps
`default_nettype none
module asm_seg_store
  import asm_cmd_pkg::*;
#(
  parameter int DEPTH = SEG_DEPTH,
  parameter int IDX_W = SEG_IDX_W
)(
  input  wire logic             i_clk,
  input  wire logic             i_wr_en,
  input  wire logic [IDX_W-1:0] i_wr_idx,
  input  wire segment_t         i_wr_seg,
  input  wire logic [IDX_W-1:0] i_rd_idx,
  output      segment_t         o_rd_seg
);

  // Storage array, no reset needed
  segment_t mem_q [DEPTH];

  // Write port
  always_ff @(posedge i_clk)
  begin
    if (i_wr_en)
    begin
      mem_q[i_wr_idx] <= i_wr_seg;
    end
  end

  // Asynchronous read, registered by the user
  assign o_rd_seg = mem_q[i_rd_idx];

endmodule
`default_nettype wire

// ---- src/asm_irq_flags.sv ----
// Sticky event flags with write-one-to-clear, mask and level interrupt
`timescale 1ns/10ps
`default_nettype none
module asm_irq_flags #(
  parameter int W = 4
)(
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_set,
  input  wire logic [W-1:0] i_clr,
  input  wire logic         i_mask_we,
  input  wire logic [W-1:0] i_mask_d,
  output      logic [W-1:0] o_stat,
  output      logic [W-1:0] o_mask,
  output      logic         o_irq
);

  logic [W-1:0] stat_q;   // Sticky flags
  logic [W-1:0] mask_q;   // Enable per flag
  logic         irq_q;    // Registered interrupt
  logic [W-1:0] stat_d;   // Next flags, set beats clear

  assign stat_d = (stat_q & ~i_clr) | i_set;

  // Flag, mask and interrupt registers
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      stat_q <= '0;
      mask_q <= '0;
      irq_q  <= 1'b0;
    end
    else
    begin
      stat_q <= stat_d;
      mask_q <= i_mask_we ? i_mask_d : mask_q;
      irq_q  <= |(stat_d & (i_mask_we ? i_mask_d : mask_q));
    end
  end

  assign o_stat = stat_q;
  assign o_mask = mask_q;
  assign o_irq  = irq_q;

endmodule
`default_nettype wire

// ---- src/asm_cmd_decoder.sv ----
// Assembled move command decoder with Wishbone command image and status
`timescale 1ns/10ps
`default_nettype none
module asm_cmd_decoder
  import asm_cmd_pkg::*;
(
  input  wire logic         I_CLK,
  input  wire logic         I_RST,
  // Wishbone classic slave
  input  wire logic         I_WB_CYC,
  input  wire logic         I_WB_STB,
  input  wire logic         I_WB_WE,
  input  wire logic [7:0]   I_WB_ADR,
  input  wire logic [3:0]   I_WB_SEL,
  input  wire logic [31:0]  I_WB_DAT,
  output      logic [31:0]  O_WB_DAT,
  output      logic         O_WB_ACK,
  // Segment execution handshake
  input  wire logic         I_SEG_DONE,
  output      logic         O_RUN_START,
  output      run_cfg_t     O_RUN_CFG,
  output      logic         O_SEG_VALID,
  output      segment_t     O_SEG,
  output      logic [3:0]   O_SEG_INDEX,
  // Encoder preset and status
  output      logic         O_ENC_LOAD,
  output      logic [31:0]  O_ENC_VALUE,
  output      logic [15:0]  O_STATUS0,
  output      logic         O_IRQ
);

  // Bus handshake
  logic         ack_q;          // Ack flop
  logic [31:0]  rdat_q;         // Read data flop
  wire          req;            // New request this cycle
  wire          wr_fire;        // Write takes effect at this edge
  wire  [5:0]   widx;           // Word index of address
  wire          adr_cmd;        // Address hits command image
  wire  [3:0]   cmd_idx;        // Command word number

  assign req     = I_WB_CYC & I_WB_STB & ~ack_q;
  assign wr_fire = I_WB_CYC & I_WB_STB & I_WB_WE & ack_q;
  assign widx    = I_WB_ADR[7:2];
  assign adr_cmd = (I_WB_ADR <= ADR_CMD_LAST) && (I_WB_ADR[1:0] == 2'b00);
  assign cmd_idx = widx[3:0];

  // Command image
  logic [15:0]  cmd_q [CMD_WORDS];   // Host command words
  wire  [15:0]  wr_word;             // Byte-merged write value
  wire  [15:0]  cur_word;            // Word being written, old value

  assign cur_word = adr_cmd ? cmd_q[cmd_idx] : CMD_WORD_RST;
  assign wr_word  = {I_WB_SEL[1] ? I_WB_DAT[15:8] : cur_word[15:8],
                     I_WB_SEL[0] ? I_WB_DAT[7:0]  : cur_word[7:0]};

  // New command on a changed word 0
  wire          cmd0_wr;
  wire          cmd_evt;
  assign cmd0_wr = wr_fire && adr_cmd && (cmd_idx == 4'(W_CMD0));
  assign cmd_evt = cmd0_wr && (wr_word != cmd_q[W_CMD0]);                          // [R5]

  // Command image registers
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      for (int i = 0; i < CMD_WORDS; i++)
      begin
        cmd_q[i] <= CMD_WORD_RST;
      end
    end
    else if (wr_fire && adr_cmd)
    begin
      cmd_q[cmd_idx] <= wr_word;
    end
  end

  // Command decode, parameter words read only per command
  wire          is_run;
  wire          is_prog;
  wire          is_preset;
  wire          is_reset;
  wire          is_seg;
  wire          is_known;
  assign is_run    = (wr_word == CMD_RUN_ASSY);   // [R1]
  assign is_prog   = (wr_word == CMD_PROG_OPEN);  // [R7]
  assign is_preset = (wr_word == CMD_PRESET_ENC); // [R6]
  assign is_reset  = (wr_word == CMD_RESET_ERR);
  assign is_seg    = (wr_word == CMD_SEGMENT);
  assign is_known  = is_run | is_prog | is_preset | is_reset | is_seg | (wr_word == CMD_NONE);

  // Encoder preset from upper and lower word
  wire  [31:0]  enc_val;
  wire          enc_ok;
  assign enc_val = {cmd_q[W_POS_HI], cmd_q[W_POS_LO]};                             // [R6]
  assign enc_ok  = ($signed(enc_val) >= ENC_MIN) && ($signed(enc_val) <= ENC_MAX); // [R6]

  // Segment assembled from the image; reserved word 8 not kept
  segment_t     seg_in;
  assign seg_in.rel_target = {cmd_q[W_POS_HI], cmd_q[W_POS_LO]}; // [R10]
  assign seg_in.speed      = {cmd_q[W_SPD_HI], cmd_q[W_SPD_LO]};
  assign seg_in.accel      = cmd_q[W_ACCEL];
  assign seg_in.decel      = cmd_q[W_DECEL];
  assign seg_in.jerk       = cmd_q[W_JERK];

  // Run style; dwell time only kept for dwell runs
  run_cfg_t     cfg_in;
  assign cfg_in.dwell    = cmd_q[W_CMD1][CMD1_DWELL_BIT];                          // [R2]
  assign cfg_in.reverse  = cmd_q[W_CMD1][CMD1_REVERSE_BIT];                        // [R2]
  assign cfg_in.dwell_ms = cfg_in.dwell ? cmd_q[W_DWELL] : 16'h0000;               // [R4]

  // Decoder state
  dec_state_t            state_q;
  dec_state_t            state_d;
  logic [SEG_CNT_W-1:0]  seg_cnt_q;      // Segments stored
  logic [SEG_IDX_W-1:0]  exec_idx_q;     // Segment being executed
  logic                  load_q;         // Fetch pending for exec_idx_q
  logic                  seg_valid_q;    // Segment offered
  segment_t              seg_q;          // Offered segment
  segment_t              seg_rd;         // Memory read data
  run_cfg_t              cfg_q;          // Latched run style
  logic                  cmd_err_q;      // Invalid command seen
  logic                  move_cmp_q;     // Profile completed
  logic                  run_start_q;    // Start pulse
  logic                  enc_load_q;     // Preset pulse
  logic [31:0]           enc_q;          // Encoder counter preset

  // State condition wires
  wire          in_prog;
  wire          seg_take;
  wire          seg_full;
  wire          seg_last;
  wire          seg_bad;
  wire          run_ok;
  wire          run_go;
  wire          exec_done;
  assign in_prog   = (state_q == ST_PROG_WAIT) || (state_q == ST_PROG_HOLD);
  assign seg_full  = (seg_cnt_q == SEG_CNT_W'(SEG_DEPTH));                          // [R16]
  assign seg_bad   = (cmd_q[W_CMD0] != CMD_SEGMENT) || seg_full;
  assign seg_take  = (state_q == ST_PROG_WAIT) && cmd_q[W_CMD0][CMD0_SEG_BIT];       // [R13]
  assign run_ok    = (seg_cnt_q != '0) && (state_q != ST_RUN);
  assign run_go    = cmd_evt && is_run && run_ok;                                   // [R1]
  assign seg_last  = (SEG_CNT_W'(exec_idx_q) == seg_cnt_q - SEG_CNT_W'(1));
  assign exec_done = (state_q == ST_RUN) && seg_valid_q && I_SEG_DONE && seg_last;

  // Error sources: unknown code, misplaced or surplus segment, run refused, bad preset, opening block during run
  wire          err_evt;
  assign err_evt = (cmd_evt && (!is_known
                                || (is_seg && !in_prog)
                                || (is_run && !run_ok)
                                || (is_preset && !enc_ok)
                                || (is_prog && state_q == ST_RUN)))
                   || (seg_take && seg_bad);                                        // [R18]

  // Next state
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:
      begin
        if (run_go)
          state_d = ST_RUN;
        else if (cmd_evt && is_prog)
          state_d = ST_PROG_WAIT;                                                   // [R8]
      end
      ST_PROG_WAIT:
      begin
        if (run_go)
          state_d = ST_RUN;                                                         // [R3]
        else if (seg_take)
          state_d = ST_PROG_HOLD;                                                   // [R13]
      end
      ST_PROG_HOLD:
      begin
        if (run_go)
          state_d = ST_RUN;
        else if (!cmd_q[W_CMD0][CMD0_SEG_BIT])
          state_d = ST_PROG_WAIT;                                                   // [R15]
      end
      ST_RUN:
      begin
        if (exec_done)
          state_d = ST_IDLE;
      end
    endcase
  end

  // State and segment count
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      state_q   <= ST_IDLE;
      seg_cnt_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      if (cmd_evt && is_prog && state_q != ST_RUN)
        seg_cnt_q <= '0;                                                            // [R7]
      else if (seg_take && !seg_bad)
        seg_cnt_q <= seg_cnt_q + SEG_CNT_W'(1);                                     // [R16]
    end
  end

  // Segment storage in arrival order
  asm_seg_store #(
    .DEPTH (SEG_DEPTH),
    .IDX_W (SEG_IDX_W)
  ) u_store (
    .i_clk    (I_CLK),
    .i_wr_en  (seg_take && !seg_bad),                                               // [R13]
    .i_wr_idx (seg_cnt_q[SEG_IDX_W-1:0]),                                           // [R19]
    .i_wr_seg (seg_in),
    .i_rd_idx (exec_idx_q),
    .o_rd_seg (seg_rd)
  );

  // Sequential execution from the first segment
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      exec_idx_q  <= '0;
      load_q      <= 1'b0;
      seg_valid_q <= 1'b0;
      seg_q       <= '0;
      cfg_q       <= '0;
      run_start_q <= 1'b0;
    end
    else
    begin
      run_start_q <= run_go;
      if (run_go)
      begin
        exec_idx_q <= '0;                                                           // [R19]
        load_q     <= 1'b1;
        cfg_q      <= cfg_in;                                                       // [R2]
      end
      else if (load_q)
      begin
        load_q      <= 1'b0;
        seg_q       <= seg_rd;
        seg_valid_q <= 1'b1;
      end
      else if (seg_valid_q && I_SEG_DONE)
      begin
        seg_valid_q <= 1'b0;
        if (!seg_last)
        begin
          exec_idx_q <= exec_idx_q + SEG_IDX_W'(1);                                 // [R19]
          load_q     <= 1'b1;
        end
      end
    end
  end

  // Error, completion and encoder preset
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      cmd_err_q  <= 1'b0;
      move_cmp_q <= 1'b0;
      enc_load_q <= 1'b0;
      enc_q      <= ENC_RST;
    end
    else
    begin
      // Error set wins over the reset command
      cmd_err_q  <= err_evt | (cmd_err_q & ~(cmd_evt & is_reset));                  // [R18]
      move_cmp_q <= exec_done | (move_cmp_q & ~(run_go | (cmd_evt & is_reset)));
      enc_load_q <= cmd_evt && is_preset && enc_ok;
      if (cmd_evt && is_preset && enc_ok)
        enc_q <= enc_val;                                                           // [R6]
    end
  end

  // Status word 0
  wire  [15:0]  status0;
  assign status0 = (16'h0001 << ST0_MODULE_OK)
                 | (16'(cmd_err_q) << ST0_CMD_ERR)                                  // [R18]
                 | (16'(state_q == ST_PROG_WAIT) << ST0_WAIT_SEG)                   // [R17]
                 | (16'(in_prog) << ST0_IN_ASSY)                                    // [R17]
                 | (16'(move_cmp_q) << ST0_MOVE_CMP);

  // Interrupt flags
  wire  [IRQ_W-1:0] ev_set;
  wire  [IRQ_W-1:0] irq_stat;
  wire  [IRQ_W-1:0] irq_mask;
  wire              irq_w;
  assign ev_set = {exec_done, run_go, seg_take && !seg_bad, err_evt};

  asm_irq_flags #(
    .W (IRQ_W)
  ) u_irq (
    .i_clk     (I_CLK),
    .i_rst     (I_RST),
    .i_set     (ev_set),
    .i_clr     ((wr_fire && I_WB_ADR == ADR_IRQ_STAT) ? I_WB_DAT[IRQ_W-1:0] : '0),
    .i_mask_we (wr_fire && I_WB_ADR == ADR_IRQ_MASK),
    .i_mask_d  (I_WB_DAT[IRQ_W-1:0]),
    .o_stat    (irq_stat),
    .o_mask    (irq_mask),
    .o_irq     (irq_w)
  );

  // Read multiplexer, unmapped reads return zero
  wire  [31:0]  rd_mux;
  assign rd_mux = adr_cmd                     ? {16'h0000, cmd_q[cmd_idx]} :
                  (I_WB_ADR == ADR_STATUS0)   ? {16'h0000, status0} :
                  (I_WB_ADR == ADR_ENC_POS)   ? enc_q :
                  (I_WB_ADR == ADR_SEG_CNT)   ? {27'h0, seg_cnt_q} :
                  (I_WB_ADR == ADR_RUN_CFG)   ? {14'h0, cfg_q} :
                  (I_WB_ADR == ADR_IRQ_STAT)  ? {28'h0, irq_stat} :
                  (I_WB_ADR == ADR_IRQ_MASK)  ? {28'h0, irq_mask} : 32'h0000_0000;

  // Bus answer one cycle after the request
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= req;
      if (req && !I_WB_WE)
        rdat_q <= rd_mux;
    end
  end

  // Outputs
  logic [15:0] status0_q;
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
      status0_q <= 16'h0000;
    else
      status0_q <= status0;
  end

  assign O_WB_ACK    = ack_q;
  assign O_WB_DAT    = rdat_q;
  assign O_RUN_START = run_start_q;
  assign O_RUN_CFG   = cfg_q;
  assign O_SEG_VALID = seg_valid_q;
  assign O_SEG       = seg_q;
  assign O_SEG_INDEX = exec_idx_q;
  assign O_ENC_LOAD  = enc_load_q;
  assign O_ENC_VALUE = enc_q;
  assign O_STATUS0   = status0_q;
  assign O_IRQ       = irq_w;

endmodule
`default_nettype wire

// ---- testbench/asm_cmd_monitor.sv ----
// Port checker for the assembled move command decoder
`timescale 1ns/10ps
`default_nettype none
module asm_cmd_monitor
  import asm_cmd_pkg::*;
(
  input wire logic        I_CLK,
  input wire logic        I_RST,
  input wire logic        I_WB_CYC,
  input wire logic        I_WB_STB,
  input wire logic        I_WB_WE,
  input wire logic        O_WB_ACK,
  input wire logic        I_SEG_DONE,
  input wire logic        O_RUN_START,
  input wire logic        O_SEG_VALID,
  input wire logic        O_ENC_LOAD,
  input wire logic [31:0] O_ENC_VALUE,
  input wire logic [15:0] O_STATUS0
);
  // Single domain, reset silences every check
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  a_ack_after_req: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK)
    else $error("bus request not answered next cycle");
  a_ack_one_pulse: assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("bus ack longer than one cycle");
  a_enc_in_range: assert property (O_ENC_LOAD |-> ($signed(O_ENC_VALUE) >= ENC_MIN) && ($signed(O_ENC_VALUE) <= ENC_MAX))
    else $error("encoder loaded outside limits");
  a_ready_in_mode: assert property (O_STATUS0[9] |-> O_STATUS0[8])
    else $error("segment ready outside programming mode");
  a_run_then_seg: assert property (O_RUN_START |=> O_SEG_VALID && !O_RUN_START)
    else $error("run start not followed by first segment");
  a_seg_holds: assert property (O_SEG_VALID && !I_SEG_DONE |=> O_SEG_VALID)
    else $error("segment withdrawn before done");
  a_seg_drops: assert property (O_SEG_VALID && I_SEG_DONE |=> !O_SEG_VALID)
    else $error("segment still offered after done");
  a_err_sticky: assert property (O_STATUS0[12] && !I_WB_WE && !$past(I_WB_WE) |=> O_STATUS0[12])
    else $error("command error cleared without a write");
endmodule
bind asm_cmd_decoder asm_cmd_monitor u_mon (.I_CLK(I_CLK), .I_RST(I_RST), .I_WB_CYC(I_WB_CYC),
  .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .O_WB_ACK(O_WB_ACK), .I_SEG_DONE(I_SEG_DONE),
  .O_RUN_START(O_RUN_START), .O_SEG_VALID(O_SEG_VALID), .O_ENC_LOAD(O_ENC_LOAD),
  .O_ENC_VALUE(O_ENC_VALUE), .O_STATUS0(O_STATUS0));
`default_nettype wire

// ---- testbench/asm_motion_model.sv ----
// Motion core model that finishes each offered segment after a delay
`timescale 1ns/10ps
`default_nettype none
module asm_motion_model (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_valid,
  input  wire logic [2:0] i_delay,
  output      logic       o_done
);
  logic [2:0] wait_q; // Cycles spent on the offered segment
  // Done only while a segment is offered and its time is up
  assign o_done = i_valid && (wait_q >= i_delay);
  // Count time on the current segment, restart between segments
  always_ff @(posedge i_clk or posedge i_rst)
    if (i_rst)
      wait_q <= 3'h0;
    else
      wait_q <= i_valid ? wait_q + 3'h1 : 3'h0;
endmodule
`default_nettype wire

// ---- testbench/tb_asm_cmd_decoder.sv ----
// Self-checking bench for the assembled move command decoder
`timescale 1ns/10ps
`default_nettype none
module tb_asm_cmd_decoder;
  import asm_cmd_pkg::*;
  logic              clk, rst, req, we, done, irq, ack, run_start, seg_valid, enc_load;
  logic [7:0]        adr;
  logic [31:0]       wdat, rdat, o_dat, enc_val;
  logic [2:0]        dly;
  logic [15:0]       st0;
  logic [3:0]        seg_idx;
  logic [15:0]       w[10];
  logic signed [31:0] pv[6];
  logic signed [31:0] last;
  run_cfg_t          run_cfg;
  segment_t          seg;
  segment_t          exp_q[$];
  int                seed, num_errors, comparisons;

  // Free running clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  asm_cmd_decoder uut (.I_CLK(clk), .I_RST(rst), .I_WB_CYC(req), .I_WB_STB(req), .I_WB_WE(we),
    .I_WB_ADR(adr), .I_WB_SEL(4'hF), .I_WB_DAT(wdat), .O_WB_DAT(o_dat), .O_WB_ACK(ack),
    .I_SEG_DONE(done), .O_RUN_START(run_start), .O_RUN_CFG(run_cfg), .O_SEG_VALID(seg_valid),
    .O_SEG(seg), .O_SEG_INDEX(seg_idx), .O_ENC_LOAD(enc_load), .O_ENC_VALUE(enc_val),
    .O_STATUS0(st0), .O_IRQ(irq));
  asm_motion_model u_core (.i_clk(clk), .i_rst(rst), .i_valid(seg_valid), .i_delay(dly), .o_done(done));

  // Compare and count
  task automatic check(string name, logic [111:0] seen, logic [111:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One classic bus cycle, released after the ack edge
  task automatic wb(logic w_en, logic [7:0] a, logic [31:0] d);
    req <= 1'b1;
    we <= w_en;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rdat = o_dat;
    req <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask
  // Read and compare masked bits
  task automatic rd(logic [7:0] a, logic [31:0] m, logic [31:0] e, string n);
    wb(1'b0, a, 32'h0);
    check(n, rdat & m, e);
  endtask
  // New command: clear word 0 first so the code always changes
  task automatic cmd(logic [15:0] c);
    wb(1'b1, ADR_CMD_BASE, 32'h0);
    wb(1'b1, ADR_CMD_BASE, {16'h0, c});
  endtask
  // Poll status until the ready bit reaches v
  task automatic wait9(logic v);
    repeat (20)
    begin
      wb(1'b0, ADR_STATUS0, 32'h0);
      if (rdat[9] === v) break;
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    wrap_up();
  end

  // Main sequence
  initial
  begin
    seed = 32'h7d08;
    num_errors = 0;
    comparisons = 0;
    rst = 1'b1;
    req = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wdat = 32'h0;
    dly = 3'h0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(ADR_STATUS0, 32'hFFFF, 32'h4000, "status after reset");
    // Error event: masked, unmasked, cleared
    wb(1'b1, ADR_IRQ_MASK, 32'h0);
    wb(1'b1, ADR_IRQ_STAT, 32'hF);
    cmd(CMD_SEGMENT);
    rd(ADR_STATUS0, 32'h1000, 32'h1000, "segment outside programming");
    check("irq masked", irq, 1'b0);
    wb(1'b1, ADR_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clk);
    check("irq unmasked", irq, 1'b1);
    wb(1'b1, ADR_IRQ_STAT, 32'h1);
    repeat (2) @(posedge clk);
    check("irq cleared", irq, 1'b0);
    rd(ADR_STATUS0, 32'h1000, 32'h1000, "error still set");
    cmd(CMD_RESET_ERR);
    rd(ADR_STATUS0, 32'h1000, 32'h0, "error reset");
    // Run refused while nothing is stored
    cmd(CMD_RUN_ASSY);
    rd(ADR_STATUS0, 32'h1080, 32'h1000, "run with nothing stored");
    cmd(CMD_RESET_ERR);
    // Encoder preset at and beyond both limits, then random values
    pv = '{ENC_MIN, ENC_MAX, ENC_MAX + 1, ENC_MIN - 1, 0, 0};
    pv[4] = $random(seed) >>> 9;
    pv[5] = $random(seed) >>> 9;
    last = ENC_RST;
    foreach (pv[i])
    begin
      wb(1'b1, 8'h08, {16'h0, pv[i][31:16]});
      wb(1'b1, 8'h0C, {16'h0, pv[i][15:0]});
      wb(1'b1, 8'h24, $random(seed));
      cmd(CMD_PRESET_ENC);
      if (pv[i] >= ENC_MIN && pv[i] <= ENC_MAX) last = pv[i];
      check("encoder value", enc_val, last[31:0]);
      rd(ADR_STATUS0, 32'h1000, (last == pv[i]) ? 32'h0 : 32'h1000, "preset error");
      cmd(CMD_RESET_ERR);
    end
    // Programming: opening block, sixteen segments and one too many
    cmd(CMD_PROG_OPEN);
    rd(ADR_STATUS0, 32'h0300, 32'h0300, "programming ready");
    for (int k = 0; k < 17; k++)
    begin
      foreach (w[i]) w[i] = 16'($random(seed)) & 16'h0FFF;
      w[2] = {16{w[2][0]}};
      w[4] = w[4] & 16'h001F;
      w[6] = w[6] | 16'h1;
      w[7] = w[7] | 16'h1;
      w[8] = 16'h0;
      for (int i = 2; i < 10; i++) wb(1'b1, 8'(4 * i), {16'h0, w[i]});
      if (k < 16) exp_q.push_back({w[2], w[3], w[4], w[5], w[6], w[7], w[9]});
      cmd(CMD_SEGMENT);
      wait9(1'b0);
      check("segment taken", rdat[9], 1'b0);
      wb(1'b1, ADR_CMD_BASE, 32'h0);
      wait9(1'b1);
      check("ready again", rdat[9], 1'b1);
      rd(ADR_SEG_CNT, 32'hFF, (k < 16) ? k + 1 : 16, "segment count");
    end
    rd(ADR_STATUS0, 32'h1000, 32'h1000, "seventeenth segment");
    cmd(CMD_RESET_ERR);
    // Run blended, then dwell, over the same stored segments
    for (int m = 0; m < 2; m++)
    begin
      w[1] = 16'(m << 9) | (16'($random(seed)) & 16'h0010);
      w[9] = 16'($random(seed));
      wb(1'b1, 8'h04, {16'h0, w[1]});
      wb(1'b1, 8'h24, {16'h0, w[9]});
      wb(1'b1, 8'h08, $random(seed));
      cmd(CMD_RUN_ASSY);
      for (int k = 0; k < 16; k++)
      begin
        dly <= 3'($random(seed));
        repeat (50) if (seg_valid !== 1'b1) @(posedge clk);
        if (k == 0) check("run config", run_cfg, {m[0], w[1][4], m[0] ? w[9] : 16'h0});
        check("segment data", seg, exp_q[k]);
        check("segment index", seg_idx, k[3:0]);
        repeat (50) if (seg_valid === 1'b1) @(posedge clk);
      end
      repeat (4) @(posedge clk);
      rd(ADR_STATUS0, 32'h0080, 32'h0080, "run complete");
    end
    wrap_up();
  end
endmodule
`default_nettype wire
